// *** verilog/pdc_pkg.sv ***
package pdc_pkg;

    // Register offsets on the system bus (byte addresses of the block)
    localparam logic [3:0] OFF_ACC0     = 4'h0;
    localparam logic [3:0] OFF_ACC1     = 4'h1;
    localparam logic [3:0] OFF_DATA0    = 4'h2;
    localparam logic [3:0] OFF_DATA1    = 4'h3;
    localparam logic [3:0] OFF_FIFO0    = 4'h4;
    localparam logic [3:0] OFF_FIFO1    = 4'h5;
    localparam logic [3:0] OFF_CTRL     = 4'h6;
    localparam logic [3:0] OFF_STATUS   = 4'h7;
    localparam logic [3:0] OFF_CFG_IDX  = 4'h8;
    localparam logic [3:0] OFF_CFG_DATA = 4'h9;

    // Byte layout of the configuration store
    localparam int CFG_PLD_AND  = 0;    // 2 arrays x 8 terms x 3 bytes
    localparam int CFG_PLD_OR   = 48;   // 2 arrays x 4 outputs
    localparam int CFG_DYN      = 56;   // 8 words x 2 bytes, low byte first
    localparam int CFG_CMP_MASK = 72;   // 2 bytes, one per comparator
    localparam int CFG_MSB      = 74;   // [2:0] most significant bit position
    localparam int CFG_POLY     = 75;
    localparam int CFG_OUT_SEL  = 76;   // 3 bytes, one nibble per output
    localparam int CFG_MISC     = 79;
    localparam int CFG_OR_MASK  = 80;
    localparam int CFG_STICKY   = 81;
    localparam int CFG_CMP_SEL  = 82;   // [1:0] compare 0, [3:2] compare 1
    localparam int CFG_BYTES    = 83;

    // Fields of the miscellaneous configuration byte
    localparam int MISC_OUT_MODE = 0;   // Per fifo: 1 = output buffer
    localparam int MISC_LOAD_ACC = 2;   // Per fifo: load accumulator, else data reg
    localparam int MISC_CAP_ACC  = 4;   // Per fifo: capture accumulator, else result

    // Values after reset and sizes
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam int         FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        PDC_INC = 3'h0, PDC_DEC = 3'h1, PDC_ADD = 3'h2, PDC_SUB = 3'h3,
        PDC_AND = 3'h4, PDC_OR  = 3'h5, PDC_XOR = 3'h6, PDC_PASS = 3'h7
    } pdc_func_t;

    typedef enum logic [1:0] {
        PDC_SH_NONE = 2'h0, PDC_SH_LEFT = 2'h1, PDC_SH_RIGHT = 2'h2, PDC_SH_SWAP = 2'h3
    } pdc_shift_t;

    // One dynamic configuration word
    typedef struct packed {
        logic [1:0] fifo_act;   // Per fifo: load from it or capture into it
        logic       crc_en;
        logic       sin_reg;    // Serial input from registered shift-out
        logic       cin_reg;    // Carry input from registered carry
        logic [1:0] dest;       // Bit i writes accumulator i
        logic       mask_en;
        pdc_shift_t shift;
        logic [1:0] srcb;       // Data 0, data 1, acc 0, acc 1
        logic       srca;       // Acc 0 or acc 1
        pdc_func_t  func;
    } pdc_dyn_t;

    typedef struct packed {
        logic [3:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pdc_bus_req_t;

endpackage

// *** verilog/pdc_cell.sv ***
// Overview of operation
// RULE1: Each logic array takes twelve routing inputs and forms eight shared product terms.
// RULE2: Each product term ANDs chosen inputs, each in true or inverted polarity.
// RULE3: Each array output ORs any of the eight product terms.
// RULE4: The cell holds two independent logic arrays of that structure.
// RULE5: An eight-bit arithmetic unit finishes each operation in one cycle, with compare logic.
// RULE6: Accumulators feed and receive the unit; data registers only feed unit and compares.
// RULE7: FIFOs load data registers or accumulators and capture accumulators or results.
// RULE8: A configuration memory of eight 16-bit words defines each datapath operation.
// RULE9: Routed inputs address that memory and may change the operation every cycle.
// RULE10: Functions are increment, decrement, add, subtract, AND, OR, XOR and pass.
// RULE11: Left shift, right shift, nibble swap and OR mask act on the result.
// RULE12: Two comparators with bit masks compare selectable register pairs.
// RULE13: Zero, all-ones and overflow conditions join compares; a selection drives routing.
// RULE14: Programmable MSB position sets width for arithmetic, shift and CRC.
// RULE15: One CRC or pseudo-random sequence step per cycle for any polynomial.
// RULE16: Each four-byte FIFO is an input or output buffer, chosen per FIFO.
// RULE17: FIFO status is selectable as datapath output toward routing.
// RULE18: Carries, shift data and conditions chain with neighbouring datapaths.
// RULE19: Carry and shift-out are registered and selectable as later inputs.
// RULE20: Six routing inputs and six routing outputs connect the datapath.
// RULE21: Firmware writes the control register; its bits drive the routing.
// RULE22: The status register is read-only and shows routing signals.
// RULE23: Sticky status bits latch a condition and clear when firmware reads status.
// RULE24: Per-block enables gate register updates of each sub-block; dp_out registers ignore blk_en[2] and status read-clears ignore blk_en[3].
module pdc_cell
    import pdc_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // System bus
    input  wire pdc_bus_req_t      bus_req,
    output logic [7:0]             bus_rdata,
    // Logic array routing
    input  wire logic [1:0][11:0]  pld_in,
    output logic [1:0][3:0]        pld_out,
    // Datapath routing: [2:0] config address, [3] serial in, [4] carry in, [5] chained condition
    input  wire logic [5:0]        dp_in,
    output logic [5:0]             dp_out,
    // Status and control routing
    output logic [7:0]             ctrl_out,
    input  wire logic [7:0]        status_in,
    // Clock controls: [0] array 0, [1] array 1, [2] datapath, [3] status
    input  wire logic [3:0]        blk_en
);

    logic [7:0]      cfg_q [0:CFG_BYTES-1];
    logic [6:0]      cfg_idx_q;
    logic [1:0][7:0] acc_q, dat_q, cmpa, cmpb, f_head;
    logic [7:0]      status_q, msk, opa, opb, bm, alu, sh, res, misc;
    logic [2:0]      msb;
    logic [8:0]      sum;
    logic [15:0]     cond;
    logic [1:0]      f_empty, f_full, f_load;
    pdc_dyn_t        dyn;
    logic            carry_q, shift_q, carry_o, sout, ov, fb, cin, sin;
    logic            dp_en, wr_cfg, rd_cfg, rd_stat;

    assign dp_en   = blk_en[2];
    assign wr_cfg  = bus_req.wr && bus_req.addr == OFF_CFG_DATA;
    assign rd_cfg  = bus_req.rd && bus_req.addr == OFF_CFG_DATA;
    assign rd_stat = bus_req.rd && bus_req.addr == OFF_STATUS;
    assign misc    = cfg_q[CFG_MISC];

    // Configuration store, written one byte at a time through an index
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            for (int i = 0; i < CFG_BYTES; i++)
                cfg_q[i] <= CFG_RST;
        else if (wr_cfg && int'(cfg_idx_q) < CFG_BYTES)
            cfg_q[cfg_idx_q] <= bus_req.wdata;
    end

    // Index auto-increments so firmware can stream the whole image
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            cfg_idx_q <= 7'h00;
        else if (bus_req.wr && bus_req.addr == OFF_CFG_IDX)
            cfg_idx_q <= bus_req.wdata[6:0];
        else if (wr_cfg || rd_cfg)
            cfg_idx_q <= cfg_idx_q + 7'h01;
    end

    // Two sum-of-products arrays; outputs are registered under their own enable
    for (genvar p = 0; p < 2; p++)
    begin : g_pld
        logic [7:0] term;
        logic [3:0] sop;
        logic [3:0] out_q;
        for (genvar t = 0; t < 8; t++)
        begin : g_term
            logic [23:0] sel;
            assign sel = {cfg_q[CFG_PLD_AND + p*24 + t*3 + 2], cfg_q[CFG_PLD_AND + p*24 + t*3 + 1],
                          cfg_q[CFG_PLD_AND + p*24 + t*3]};
            // Unselected inputs drop out of the AND
            assign term[t] = &((~sel[11:0] | pld_in[p]) & (~sel[23:12] | ~pld_in[p])); // RULE1 RULE2
        end
        for (genvar o = 0; o < 4; o++)
        begin : g_or
            assign sop[o] = |(term & cfg_q[CFG_PLD_OR + p*4 + o]); // RULE3
        end
        always_ff @(posedge ref_clk)
        begin
            if (!reset_n)
                out_q <= 4'h0;
            else if (blk_en[p]) // RULE4 RULE24
                out_q <= sop;
        end
        assign pld_out[p] = out_q;
    end

    // Operation chosen per cycle by the routed address
    assign dyn = pdc_dyn_t'({cfg_q[CFG_DYN + {dp_in[2:0], 1'b1}], cfg_q[CFG_DYN + {dp_in[2:0], 1'b0}]}); // RULE8 RULE9

    // Single-cycle arithmetic, shifter and CRC step, limited to the programmed width except the nibble swap
    always_comb
    begin
        msb = cfg_q[CFG_MSB][2:0];
        msk = ~(8'hFE << msb); // RULE14
        opa = dyn.srca ? acc_q[1] : acc_q[0]; // RULE6
        unique case (dyn.srcb)
            2'h0: opb = dat_q[0];
            2'h1: opb = dat_q[1];
            2'h2: opb = acc_q[0];
            2'h3: opb = acc_q[1];
        endcase
        cin = dyn.cin_reg ? carry_q : dp_in[4]; // RULE18 RULE19
        sin = dyn.sin_reg ? shift_q : dp_in[3]; // RULE19
        bm  = (dyn.func == PDC_SUB) ? ~opb : opb;
        unique case (dyn.func) // RULE5 RULE10
            PDC_INC:  sum = {1'b0, opa} + 9'h001;
            PDC_DEC:  sum = {1'b0, opa} + 9'h0FF;
            PDC_ADD,
            PDC_SUB:  sum = {1'b0, opa} + {1'b0, bm} + {8'h00, cin};
            PDC_AND:  sum = {1'b0, opa & opb};
            PDC_OR:   sum = {1'b0, opa | opb};
            PDC_XOR:  sum = {1'b0, opa ^ opb};
            PDC_PASS: sum = {1'b0, opa};
        endcase
        // Carry is taken just above the programmed MSB
        carry_o = sum[{1'b0, msb} + 4'h1];
        ov = (dyn.func == PDC_ADD || dyn.func == PDC_SUB)
             && opa[msb] == bm[msb] && sum[msb] != opa[msb]; // RULE13
        alu = sum[7:0] & msk;
        unique case (dyn.shift) // RULE11
            PDC_SH_NONE:  sh = alu;
            PDC_SH_LEFT:  sh = ((alu << 1) | {7'h00, sin}) & msk;
            PDC_SH_RIGHT: sh = ((alu >> 1) & ~(8'h01 << msb)) | ({7'h00, sin} << msb);
            PDC_SH_SWAP:  sh = {alu[3:0], alu[7:4]};
        endcase
        // Outside a CRC step, only real shifts push a bit out; swap and no-shift leave it low
        sout = (dyn.shift == PDC_SH_LEFT) ? alu[msb] : ((dyn.shift == PDC_SH_RIGHT) ? alu[0] : 1'b0);
        // Galois step: feedback is serial input XOR the MSB; zero serial input gives a sequence
        fb = sin ^ opa[msb];
        if (dyn.crc_en) // RULE15
        begin
            sh   = ((opa << 1) & msk) ^ (fb ? (cfg_q[CFG_POLY] & msk) : 8'h00);
            sout = opa[msb];
        end
        res = dyn.mask_en ? (sh | cfg_q[CFG_OR_MASK]) : sh; // RULE11
    end

    // Two masked comparators over selectable register pairs
    for (genvar c = 0; c < 2; c++)
    begin : g_cmp
        logic [1:0] pair;
        assign pair = cfg_q[CFG_CMP_SEL][2*c +: 2];
        assign cmpa[c] = ((pair == 2'h1 || pair == 2'h3) ? acc_q[1] : acc_q[0]) & cfg_q[CFG_CMP_MASK + c]; // RULE12
        assign cmpb[c] = (pair == 2'h0 ? dat_q[0] : pair == 2'h1 ? dat_q[1] :
                          pair == 2'h2 ? acc_q[1] : dat_q[0]) & cfg_q[CFG_CMP_MASK + c];
        assign cond[2*c]     = cmpa[c] == cmpb[c];
        assign cond[2*c + 1] = cmpa[c] <  cmpb[c];
    end

    // Condition set; FIFO status and chained condition are selectable like the rest
    assign cond[15:4] = {dp_in[5], f_full[1], f_empty[1], f_full[0], f_empty[0], shift_q, carry_q, ov, // RULE17 RULE18
                         acc_q[1] == 8'hFF, acc_q[0] == 8'hFF, acc_q[1] == 8'h00, acc_q[0] == 8'h00}; // RULE13

    // Six registered outputs, each picking one condition
    for (genvar k = 0; k < 6; k++)
    begin : g_out
        logic [3:0] pick;
        logic       o_q;
        assign pick = cfg_q[CFG_OUT_SEL + k/2][4*(k%2) +: 4];
        always_ff @(posedge ref_clk)
        begin
            if (!reset_n)
                o_q <= 1'b0;
            else
                o_q <= cond[pick]; // RULE20
        end
        assign dp_out[k] = o_q;
    end

    // Carry and shift-out kept for later cycles, e.g. two halves of a 16-bit value
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            carry_q <= 1'b0;
            shift_q <= 1'b0;
        end
        else if (dp_en) // RULE19 RULE24
        begin
            carry_q <= carry_o;
            shift_q <= sout;
        end
    end

    // Two four-byte FIFOs; direction fixed per FIFO by configuration
    for (genvar f = 0; f < 2; f++)
    begin : g_fifo
        logic [7:0] mem [0:FIFO_DEPTH-1];
        logic [1:0] wp_q;
        logic [1:0] rp_q;
        logic [2:0] cnt_q;
        logic       out_mode;
        logic       push;
        logic       pop;
        logic       dp_act;
        logic [7:0] din;
        assign out_mode = misc[MISC_OUT_MODE + f];
        assign dp_act   = dp_en && dyn.fifo_act[f];
        // Bus writes to a full FIFO and reads of an empty one are dropped
        assign push = !f_full[f] && (out_mode ? dp_act
                      : (bus_req.wr && bus_req.addr == OFF_FIFO0 + 4'(f))); // RULE16
        assign pop  = !f_empty[f] && (out_mode ? (bus_req.rd && bus_req.addr == OFF_FIFO0 + 4'(f))
                      : dp_act); // RULE16
        assign din  = out_mode ? (misc[MISC_CAP_ACC + f] ? acc_q[f] : res) : bus_req.wdata; // RULE7
        assign f_empty[f] = cnt_q == 3'h0;
        assign f_full[f]  = cnt_q == 3'(FIFO_DEPTH);
        assign f_head[f]  = f_empty[f] ? 8'h00 : mem[rp_q];
        assign f_load[f]  = pop && !out_mode;
        always_ff @(posedge ref_clk)
        begin
            if (push)
                mem[wp_q] <= din;
        end
        always_ff @(posedge ref_clk)
        begin
            if (!reset_n)
            begin
                wp_q  <= 2'h0;
                rp_q  <= 2'h0;
                cnt_q <= 3'h0;
            end
            else
            begin
                wp_q  <= wp_q + {1'b0, push};
                rp_q  <= rp_q + {1'b0, pop};
                cnt_q <= cnt_q + {2'h0, push} - {2'h0, pop};
            end
        end
    end

    // Accumulators: bus write first, then FIFO load, then arithmetic result
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            acc_q <= '0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (bus_req.wr && bus_req.addr == OFF_ACC0 + 4'(i))
                    acc_q[i] <= bus_req.wdata;
                else if (f_load[i] && misc[MISC_LOAD_ACC + i]) // RULE7
                    acc_q[i] <= f_head[i];
                else if (dp_en && dyn.dest[i]) // RULE6 RULE24
                    acc_q[i] <= res;
            end
        end
    end

    // Data registers are never written by the arithmetic unit
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            dat_q <= '0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (bus_req.wr && bus_req.addr == OFF_DATA0 + 4'(i))
                    dat_q[i] <= bus_req.wdata;
                else if (f_load[i] && !misc[MISC_LOAD_ACC + i]) // RULE6 RULE7
                    dat_q[i] <= f_head[i];
            end
        end
    end

    // Control register drives the routing directly
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            ctrl_out <= CTRL_RST;
        else if (bus_req.wr && bus_req.addr == OFF_CTRL)
            ctrl_out <= bus_req.wdata; // RULE21
    end

    // Status: sticky bits set over a read-clear, so no event is lost
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            status_q <= STATUS_RST;
        else
            status_q <= (cfg_q[CFG_STICKY] & ((status_q & {8{!rd_stat}}) | (status_in & {8{blk_en[3]}}))) // RULE23
                      | (~cfg_q[CFG_STICKY] & (blk_en[3] ? status_in : status_q)); // RULE22 RULE24
    end

    // Read data is captured on the read strobe and held until the next read
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            bus_rdata <= 8'h00;
        else if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                OFF_ACC0, OFF_ACC1:   bus_rdata <= acc_q[bus_req.addr[0]];
                OFF_DATA0, OFF_DATA1: bus_rdata <= dat_q[bus_req.addr[0]];
                OFF_FIFO0, OFF_FIFO1: bus_rdata <= f_head[bus_req.addr[0]];
                OFF_CTRL:             bus_rdata <= ctrl_out;
                OFF_STATUS:           bus_rdata <= status_q; // RULE22
                OFF_CFG_IDX:          bus_rdata <= {1'b0, cfg_idx_q};
                OFF_CFG_DATA:         bus_rdata <= (int'(cfg_idx_q) < CFG_BYTES) ? cfg_q[cfg_idx_q] : 8'h00;
                default:              bus_rdata <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic quiet_acc0;
    assign quiet_acc0 = !(bus_req.wr && bus_req.addr == OFF_ACC0) && !f_load[0];

    a_ctrl_write: assert property (bus_req.wr && bus_req.addr == OFF_CTRL |=> ctrl_out == $past(bus_req.wdata)) // RULE21
        else $error("control register did not take the bus write");
    a_sticky_set: assert property (blk_en[3] && (status_in & cfg_q[CFG_STICKY]) != 8'h00 // RULE23
        |=> (status_q & $past(status_in & cfg_q[CFG_STICKY])) == $past(status_in & cfg_q[CFG_STICKY]))
        else $error("sticky status bit lost its event");
    a_sticky_clear: assert property (rd_stat // RULE23
        |=> (status_q & cfg_q[CFG_STICKY] & ~$past(status_in & {8{blk_en[3]}})) == 8'h00)
        else $error("sticky status bits not cleared by read");
    a_fifo_bound: assert property (g_fifo[0].cnt_q <= 3'h4 && g_fifo[1].cnt_q <= 3'h4) // RULE16
        else $error("fifo count beyond depth");
    a_fifo_fill: assert property (f_full[0] && bus_req.wr && bus_req.addr == OFF_FIFO0 && !misc[0] // RULE16
        && !(dp_en && dyn.fifo_act[0]) |=> f_full[0])
        else $error("full input fifo changed level on bus write");
    a_alu_inc: assert property (dp_en && dyn.func == PDC_INC && dyn.dest == 2'h1 && !dyn.srca // RULE10
        && dyn.shift == PDC_SH_NONE && !dyn.mask_en && !dyn.crc_en && msb == 3'h7 && quiet_acc0
        |=> acc_q[0] == $past(acc_q[0]) + 8'h01)
        else $error("increment result wrong");
    a_dp_hold: assert property (!dp_en && quiet_acc0 |=> $stable(acc_q[0]) && $stable(carry_q)) // RULE24
        else $error("datapath updated while its enable was low");
    a_pld_empty: assert property (cfg_q[CFG_PLD_OR] == 8'h00 && blk_en[0] |=> !pld_out[0][0]) // RULE3
        else $error("array output set with no product terms selected");
    a_cond_route: assert property (cfg_q[CFG_OUT_SEL][3:0] == 4'h4 && $stable(cfg_q[CFG_OUT_SEL]) // RULE13
        |=> dp_out[0] == ($past(acc_q[0]) == 8'h00))
        else $error("zero detect not routed to output");

    c_fifo_full: cover property (f_full[0] ##1 !f_full[0] && !f_empty[0]);
    c_crc_step: cover property (dp_en && dyn.crc_en ##1 dp_en && dyn.crc_en);
    c_sticky_rd: cover property (rd_stat && blk_en[3] && (status_in & cfg_q[CFG_STICKY]) != 8'h00);
    c_carry_chain: cover property (dp_en && carry_o ##1 dp_en && dyn.cin_reg);

endmodule

// *** dv/pdc_route_model.sv ***
// Routing matrix stand-in: control bits are routed back into status inputs
module pdc_route_model
    import pdc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Routing connections
    input  wire logic [7:0]  ctrl_out,
    output logic [7:0]       status_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // One routing stage of delay, so status trails control by a cycle
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            status_in <= 8'h00;
        else
            status_in <= ctrl_out;
    end
endmodule

// *** dv/testbench.sv ***
module testbench
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             ref_clk = 1'b0;
    logic             reset_n = 1'b0;
    pdc_bus_req_t     bus_req = '0;
    logic [7:0]       bus_rdata;
    logic [1:0][3:0]  pld_out;
    logic [1:0][11:0] pld_in = '0;
    logic [5:0]       dp_in = '0;
    logic [5:0]       dp_out;
    logic [7:0]       ctrl_out;
    logic [7:0]       status_in;
    logic [3:0]       blk_en = '0;
    logic [7:0]       rd_val;
    int               n_mismatch = 0;
    int               checks = 0;
    // Working registers and control reset to zero; 0xA is unmapped
    logic [3:0] rst_addr [6] = '{OFF_ACC0, OFF_ACC1, OFF_DATA0, OFF_DATA1, OFF_CTRL, 4'hA};
    // Dynamic word low bytes (acc0 op D0) and results for acc0=3C, D0=0F
    logic [7:0] op_lo [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h47, 8'h87, 8'hC7};
    logic [7:0] op_exp [11] = '{8'h3D, 8'h3B, 8'h4B, 8'h2D, 8'h0C, 8'h3F, 8'h33, 8'h3C, 8'h78, 8'h1E, 8'hC3};

    always #2.5 ref_clk = ~ref_clk;

    pdc_cell dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
                  .pld_in(pld_in), .pld_out(pld_out), .dp_in(dp_in), .dp_out(dp_out),
                  .ctrl_out(ctrl_out), .status_in(status_in), .blk_en(blk_en));
    pdc_route_model model (.ref_clk(ref_clk), .reset_n(reset_n), .ctrl_out(ctrl_out), .status_in(status_in));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus request held over one rising edge; read data lands on that edge
    task automatic bus_op(input logic [3:0] a, input logic w, input logic [7:0] d);
        @(negedge ref_clk);
        bus_req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge ref_clk);
        bus_req <= '0;
        rd_val = bus_rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_op(a, 1'b1, d);
    endtask

    task automatic chk(input logic [3:0] a, input logic [7:0] exp);
        bus_op(a, 1'b0, 8'h00);
        cmp(rd_val, exp);
    endtask

    task automatic cfg(input int idx, input logic [7:0] d);
        wr(OFF_CFG_IDX, 8'(idx));
        wr(OFF_CFG_DATA, d);
    endtask

    // Datapath enabled for n edges with a fixed routed input pattern
    task automatic run(input logic [5:0] din, input int n);
        @(negedge ref_clk);
        dp_in <= din;
        blk_en[2] <= 1'b1;
        repeat (n) @(negedge ref_clk);
        blk_en[2] <= 1'b0;
    endtask

    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(negedge ref_clk);
        reset_n <= 1'b1;
        // Array 0 and status capture run throughout; the datapath only inside run and the word 1/2 loop
        blk_en <= 4'h9;
        foreach (rst_addr[i]) chk(rst_addr[i], 8'h00);
        for (int i = 0; i < 4; i++) wr(4'(i), 8'(8'hA0 + i * 17));
        for (int i = 0; i < 4; i++) chk(4'(i), 8'(8'hA0 + i * 17));
        wr(OFF_CTRL, 8'h5A);
        cmp(ctrl_out, 8'h5A);
        // Status trails control by the routing stage plus the status register
        @(negedge ref_clk);
        chk(OFF_STATUS, 8'h5A);
        wr(OFF_STATUS, 8'hFF);
        chk(OFF_STATUS, 8'h5A);
        // Sticky bit keeps a pulse until firmware reads it
        cfg(CFG_STICKY, 8'h01);
        wr(OFF_CTRL, 8'h01);
        wr(OFF_CTRL, 8'h00);
        chk(OFF_STATUS, 8'h01);
        chk(OFF_STATUS, 8'h00);
        // Full eight-bit width, every function and shift through word 0
        cfg(CFG_MSB, 8'h07);
        wr(OFF_DATA0, 8'h0F);
        for (int i = 0; i < 11; i++)
        begin
            cfg(CFG_DYN, op_lo[i]);
            wr(OFF_CFG_DATA, 8'h02);
            wr(OFF_ACC0, 8'h3C);
            run({1'b0, (i == 3), 4'h0}, 1); // Carry in high only for the subtract
            chk(OFF_ACC0, op_exp[i]);
        end
        // Word 1 increments, word 2 adds D0; address switches every edge
        cfg(CFG_DYN + 2, 8'h00);
        wr(OFF_CFG_DATA, 8'h02);
        wr(OFF_CFG_DATA, 8'h02);
        wr(OFF_CFG_DATA, 8'h02);
        wr(OFF_ACC0, 8'h10);
        @(negedge ref_clk);
        blk_en[2] <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            dp_in <= k[0] ? 6'h02 : 6'h01;
            @(negedge ref_clk);
        end
        blk_en[2] <= 1'b0;
        chk(OFF_ACC0, 8'h31);
        // Input fifo 0 loads data 0; fifth byte refused, empty load dropped
        cfg(CFG_OUT_SEL, 8'hB4);
        cfg(CFG_DYN, 8'h07);
        wr(OFF_CFG_DATA, 8'h40);
        for (int k = 1; k < 6; k++) wr(OFF_FIFO0, 8'(17 * k));
        cmp({7'b0, dp_out[1]}, 8'h00);
        chk(OFF_FIFO0, 8'h11);
        for (int k = 1; k < 6; k++)
        begin
            run(6'h00, 1);
            chk(OFF_DATA0, 8'(17 * ((k < 5) ? k : 4)));
        end
        cmp({7'b0, dp_out[1]}, 8'h01);
        // Array 0 output 0 is input 0 AND NOT input 1; no other output has a term
        cfg(CFG_PLD_AND, 8'h01);
        wr(OFF_CFG_DATA, 8'h20);
        cfg(CFG_PLD_OR, 8'h01);
        pld_in[0] <= 12'h001;
        @(negedge ref_clk);
        cmp(pld_out, 8'h01);
        pld_in[0] <= 12'h003;
        @(negedge ref_clk);
        cmp(pld_out, 8'h00);
        complete_run();
    end

    // Whole sequence needs well under 2,000 cycles
    initial
    begin
        #50us;
        n_mismatch++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule
